/* File: rtl/adc_ctl_regs.vh */
// constants for the converter control block
`ifndef ADC_CTL_REGS_VH
`define ADC_CTL_REGS_VH
`define DIV_W 3
`define PRESCALE_W 7
`define SRC_W 3
`define CHAN_W 4
`define REF_W 2
`define PHASE_W 6
`define SRC_EXT_A 3'h0
`define SRC_BANDGAP 3'h1
`define SRC_TEMP 3'h2
`define SRC_SMOKE0 3'h3
`define SRC_SMOKE1 3'h4
`define SRC_LINE 3'h5
`define SRC_EXT_B 3'h6
`define REF_PIN 2'h0
`define REF_TEMP 2'h2
`define SAMPLE_NORMAL 6'h04
`define SAMPLE_TEMP 6'h2E
`define CONVERT_CYCLES 6'h0C
`define ONEHOT_SOURCES 8
`endif

/* File: rtl/adc_clock_divider.v */
// power-of-two divider producing one-cycle conversion clock ticks
`timescale 1ns/1ns
`include "adc_ctl_regs.vh"
module adc_clock_divider
(
  // clock and reset
  input wire clock_i,
  input wire rst_b_i,
  // control
  input wire run_i,
  input wire [`DIV_W-1:0] divider_select_i,
  // tick out
  output reg tick_o
);
  reg [`PRESCALE_W-1:0] count;
  wire [`PRESCALE_W-1:0] limit;

  // limit is 2^n - 1 for the selected divide ratio
  assign limit = (7'h01 << divider_select_i) - 7'h01;

  always @(posedge clock_i)
  begin
    if (!rst_b_i || !run_i)
    begin
      count <= 7'h00;
      tick_o <= 1'b0;
    end
    else if (count >= limit)
    begin
      count <= 7'h00;
      tick_o <= 1'b1;
    end
    else
    begin
      count <= count + 7'h01;
      tick_o <= 1'b0;
    end
  end
endmodule

/* File: rtl/adc_conversion_control.v */
// converter control: start detect, busy, sequencing, source and reference routing
//
// Summary of operation
// - start high-then-low pulse launches one conversion
// - busy flag sets when conversion launches
// - busy flag clears when conversion ends
// - completion sets interrupt request flag; interrupt output gated by enable
// - conversion clock is system clock over 2^n
// - power enable needed for converter operation
// - reference select: pin, supply, temp reference
// - analog pin drops its digital functions
// - analog pin drops its pull-high
// - analog selection overrides port direction
// - source 000/110 routes channel-selected external pin when that pin is analog
// - sources 001-101 route internal signals in order
// - normal conversion is 4 sample, 12 convert
// - temperature conversion is 46 sample, 12 convert
// - alignment bit selects result byte layout
`timescale 1ns/1ns
`include "adc_ctl_regs.vh"
module adc_conversion_control
(
  // clock and reset
  input wire clock_i,
  input wire rst_b_i,
  // software control bits
  input wire start_i,
  input wire converter_power_enable_i,
  input wire [`DIV_W-1:0] conversion_clock_divider_select_i,
  input wire low_current_mode_select_i,
  input wire [`REF_W-1:0] reference_source_select_i,
  input wire temp_sensor_enable_i,
  input wire [`SRC_W-1:0] input_source_select_i,
  input wire [`CHAN_W-1:0] external_channel_select_i,
  input wire result_alignment_select_i,
  input wire interrupt_enable_i,
  input wire irq_clear_i,
  // pin-function select, one bit per analog input pin
  input wire [15:0] pin_function_select_lo_i,
  input wire [15:0] pin_function_select_hi_i,
  // analog core
  input wire [11:0] core_result_i,
  // status
  output reg conversion_busy_flag_o,
  output reg irq_flag_o,
  output reg interrupt_o,
  output reg [7:0] result_high_reg_o,
  output reg [7:0] result_low_reg_o,
  // analog core control
  output reg core_power_o,
  output reg core_low_current_o,
  output reg core_temp_sensor_on_o,
  output reg core_sample_o,
  output reg core_convert_o,
  output reg core_clock_tick_o,
  output reg [2:0] reference_route_o,
  output reg [`ONEHOT_SOURCES-1:0] internal_route_o,
  // pad control per analog input pin
  output reg [15:0] analog_input_pin_o,
  output reg [15:0] pin_digital_disable_o,
  output reg [15:0] pin_pullup_disable_o,
  output reg [15:0] pin_direction_override_o
);
  localparam IDLE = 2'h0;
  localparam SAMPLE = 2'h1;
  localparam CONVERT = 2'h2;

  reg [1:0] state;
  reg start_seen;
  reg [`PHASE_W-1:0] phase_count;
  reg [`SRC_W-1:0] held_source;
  wire tick;
  wire launch;
  wire done;
  wire [15:0] pin_analog;
  reg [15:0] channel_onehot;
  reg [2:0] next_ref;
  reg [`ONEHOT_SOURCES-1:0] next_route;

  function is_external;
    input [`SRC_W-1:0] src;
    begin
      is_external = (src == `SRC_EXT_A) || (src == `SRC_EXT_B);
    end
  endfunction

  // a pin counts as analog when either select half marks it
  assign pin_analog = pin_function_select_lo_i | pin_function_select_hi_i;

  // edge detect on the start bit; a pulse while unpowered is dropped
  assign launch = start_seen && !start_i && converter_power_enable_i
    && (state == IDLE);

  assign done = (state == CONVERT) && tick && (phase_count == `CONVERT_CYCLES - 6'h01);

  adc_clock_divider u_div
  (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    // halt on the final tick so no extra conversion clock reaches the core
    .run_i(state != IDLE && !done),
    .divider_select_i(conversion_clock_divider_select_i),
    .tick_o(tick)
  );

  always @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      start_seen <= 1'b0;
    end
    else
    begin
      start_seen <= start_i;
    end
  end

  // sequencer: the source is latched at launch so a mid-conversion
  // rewrite cannot change the sample length
  always @(posedge clock_i)
  begin
    if (!rst_b_i || !converter_power_enable_i)
    begin
      state <= IDLE;
      phase_count <= 6'h00;
      held_source <= `SRC_EXT_A;
    end
    else
    begin
      case (state)
        IDLE:
        begin
          phase_count <= 6'h00;
          if (launch)
          begin
            held_source <= input_source_select_i;
            state <= SAMPLE;
          end
        end
        SAMPLE:
        begin
          if (tick)
          begin
            if ((held_source == `SRC_TEMP &&
                 phase_count == `SAMPLE_TEMP - 6'h01) ||
                (held_source != `SRC_TEMP &&
                 phase_count == `SAMPLE_NORMAL - 6'h01))
            begin
              phase_count <= 6'h00;
              state <= CONVERT;
            end
            else
            begin
              phase_count <= phase_count + 6'h01;
            end
          end
        end
        CONVERT:
        begin
          if (tick)
          begin
            if (done)
            begin
              phase_count <= 6'h00;
              state <= IDLE;
            end
            else
            begin
              phase_count <= phase_count + 6'h01;
            end
          end
        end
        default:
        begin
          state <= IDLE;
        end
      endcase
    end
  end

  // busy, irq and result; irq set wins over clear
  always @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      conversion_busy_flag_o <= 1'b0;
      irq_flag_o <= 1'b0;
      interrupt_o <= 1'b0;
      result_high_reg_o <= 8'h00;
      result_low_reg_o <= 8'h00;
    end
    else
    begin
      if (launch)
        conversion_busy_flag_o <= 1'b1;
      else if (done || !converter_power_enable_i)
        conversion_busy_flag_o <= 1'b0;
      if (done)
        irq_flag_o <= 1'b1;
      else if (irq_clear_i)
        irq_flag_o <= 1'b0;
      interrupt_o <= (irq_flag_o || done) && interrupt_enable_i;
      // result holds while power is off since no conversion completes
      if (done)
      begin
        if (result_alignment_select_i)
        begin
          result_high_reg_o <= {4'h0, core_result_i[11:8]};
          result_low_reg_o <= core_result_i[7:0];
        end
        else
        begin
          result_high_reg_o <= core_result_i[11:4];
          result_low_reg_o <= {4'h0, core_result_i[3:0]};
        end
      end
    end
  end

  always @*
  begin
    next_ref = 3'h0;
    case (reference_source_select_i)
      `REF_PIN: next_ref = 3'h1;
      `REF_TEMP: next_ref = 3'h4;
      default: next_ref = 3'h2;
    endcase
    next_route = {`ONEHOT_SOURCES{1'b0}};
    if (!is_external(input_source_select_i))
      next_route[input_source_select_i] = 1'b1;
    channel_onehot = 16'h0000;
    if (is_external(input_source_select_i))
      channel_onehot[external_channel_select_i] = 1'b1;
  end

  always @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      core_power_o <= 1'b0;
      core_low_current_o <= 1'b0;
      core_temp_sensor_on_o <= 1'b0;
      core_sample_o <= 1'b0;
      core_convert_o <= 1'b0;
      core_clock_tick_o <= 1'b0;
      reference_route_o <= 3'h0;
      internal_route_o <= {`ONEHOT_SOURCES{1'b0}};
      analog_input_pin_o <= 16'h0000;
      pin_digital_disable_o <= 16'h0000;
      pin_pullup_disable_o <= 16'h0000;
      pin_direction_override_o <= 16'h0000;
    end
    else
    begin
      core_power_o <= converter_power_enable_i;
      core_low_current_o <= low_current_mode_select_i;
      core_temp_sensor_on_o <= temp_sensor_enable_i;
      core_sample_o <= (state == SAMPLE);
      core_convert_o <= (state == CONVERT);
      core_clock_tick_o <= tick;
      reference_route_o <= next_ref;
      internal_route_o <= next_route;
      analog_input_pin_o <= channel_onehot & pin_analog;
      pin_digital_disable_o <= pin_analog;
      pin_pullup_disable_o <= pin_analog;
      pin_direction_override_o <= pin_analog;
    end
  end
endmodule

/* File: verif/adc_core_model.sv */
// behavioural analog core returning a fixed code
`timescale 1ns/1ns
module adc_core_model
#(
  parameter logic [11:0] CODE = 12'hA5C
)
(
  input wire logic clock_i,
  input wire logic power_i,
  output logic [11:0] result_o
);
  // unpowered output wanders so a sample taken without power is caught
  always @(posedge clock_i)
    result_o <= power_i ? CODE : ~result_o;
endmodule

/* File: verif/adc_ctl_monitor.sv */
// assertion checker for the converter control block
`timescale 1ns/1ns
module adc_ctl_monitor
(
  input wire logic clock_i, rst_b_i, start_i, converter_power_enable_i,
  input wire logic interrupt_enable_i, irq_clear_i, conversion_busy_flag_o,
  input wire logic irq_flag_o, interrupt_o,
  input wire logic [1:0] reference_source_select_i,
  input wire logic [2:0] input_source_select_i, reference_route_o,
  input wire logic [7:0] internal_route_o,
  input wire logic [15:0] pin_function_select_lo_i, pin_function_select_hi_i,
  input wire logic [15:0] pin_digital_disable_o, pin_pullup_disable_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_busy_launch: assert property (
    $past(start_i) && !start_i && converter_power_enable_i && !conversion_busy_flag_o
    |=> conversion_busy_flag_o) else $error("busy not set on launch");
  a_power_off: assert property (
    !converter_power_enable_i |=> !conversion_busy_flag_o) else $error("busy while off");
  a_irq_done: assert property (
    $fell(conversion_busy_flag_o) && $past(converter_power_enable_i) |-> irq_flag_o)
    else $error("no request at completion");
  a_abort_quiet: assert property (
    $fell(conversion_busy_flag_o) && !$past(converter_power_enable_i) && !$past(irq_flag_o)
    |-> !irq_flag_o) else $error("request after abort");
  a_irq_hold: assert property (
    irq_flag_o && !irq_clear_i |=> irq_flag_o) else $error("request lost");
  a_irq_clear: assert property (
    irq_clear_i && !conversion_busy_flag_o |=> !irq_flag_o) else $error("request kept");
  a_int_gate: assert property (
    irq_flag_o && interrupt_enable_i |=> interrupt_o) else $error("interrupt missing");
  a_ref_route: assert property (
    1 |=> reference_route_o == ($past(reference_source_select_i) == 2'h0 ? 3'h1 :
    $past(reference_source_select_i) == 2'h2 ? 3'h4 : 3'h2)) else $error("bad reference");
  a_int_route: assert property (
    input_source_select_i inside {[3'h1:3'h5]}
    |=> internal_route_o == 8'h01 << $past(input_source_select_i)) else $error("bad source");
  a_pad_mask: assert property (
    1 |=> pin_pullup_disable_o == pin_digital_disable_o && pin_digital_disable_o ==
    ($past(pin_function_select_lo_i) | $past(pin_function_select_hi_i))) else $error("pads");
  c_done: cover property ($fell(conversion_busy_flag_o) && irq_flag_o);
  c_abort: cover property ($fell(conversion_busy_flag_o) && !converter_power_enable_i);
  c_int: cover property (interrupt_o);
endmodule
bind adc_conversion_control adc_ctl_monitor mon
(
  .clock_i(clock_i),
  .rst_b_i(rst_b_i),
  .start_i(start_i),
  .converter_power_enable_i(converter_power_enable_i),
  .interrupt_enable_i(interrupt_enable_i),
  .irq_clear_i(irq_clear_i),
  .conversion_busy_flag_o(conversion_busy_flag_o),
  .irq_flag_o(irq_flag_o),
  .interrupt_o(interrupt_o),
  .reference_source_select_i(reference_source_select_i),
  .input_source_select_i(input_source_select_i),
  .reference_route_o(reference_route_o),
  .internal_route_o(internal_route_o),
  .pin_function_select_lo_i(pin_function_select_lo_i),
  .pin_function_select_hi_i(pin_function_select_hi_i),
  .pin_digital_disable_o(pin_digital_disable_o),
  .pin_pullup_disable_o(pin_pullup_disable_o)
);

/* File: verif/testbench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [2:0] src; logic [1:0] rs; logic [2:0] dv; logic [3:0] ch; logic al;
    logic [7:0] eh, el, ir; logic [2:0] er; logic [15:0] ep;
  } row_t;
  row_t rows [8] = '{
    '{3'h0, 2'h0, 3'h0, 4'h3, 1'b0, 8'hA5, 8'h0C, 8'h00, 3'h1, 16'h0008},
    '{3'h1, 2'h1, 3'h1, 4'h0, 1'b1, 8'h0A, 8'h5C, 8'h02, 3'h2, 16'h0000},
    '{3'h2, 2'h2, 3'h5, 4'h0, 1'b0, 8'hA5, 8'h0C, 8'h04, 3'h4, 16'h0000},
    '{3'h3, 2'h3, 3'h3, 4'h0, 1'b1, 8'h0A, 8'h5C, 8'h08, 3'h2, 16'h0000},
    '{3'h4, 2'h0, 3'h4, 4'h0, 1'b0, 8'hA5, 8'h0C, 8'h10, 3'h1, 16'h0000},
    '{3'h5, 2'h1, 3'h6, 4'h0, 1'b1, 8'h0A, 8'h5C, 8'h20, 3'h2, 16'h0000},
    '{3'h6, 2'h2, 3'h7, 4'hF, 1'b0, 8'hA5, 8'h0C, 8'h00, 3'h4, 16'h8000},
    '{3'h0, 2'h3, 3'h2, 4'h4, 1'b1, 8'h0A, 8'h5C, 8'h00, 3'h2, 16'h0000}};
  row_t r;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic start_i = 1'b0;
  logic pwr = 1'b0;
  logic temp_sensor_enable = 1'b0;
  logic ien = 1'b0;
  logic clr = 1'b0;
  logic [2:0] src = 3'h0;
  logic [1:0] rs = 2'h0;
  logic [2:0] dv = 3'h0;
  logic [3:0] ch = 4'h0;
  logic al = 1'b0;
  logic [15:0] lo = 16'h0000;
  logic [15:0] hi = 16'h0000;
  logic lcm = 1'b0;
  logic [11:0] core;
  logic busy, irq, intr, c_pwr, tick, lc, ts, smp, cnv;
  logic [7:0] rh, rl, ir;
  logic [2:0] er;
  logic [15:0] ep, dis, pu, dr;
  int bad_count = 0;
  int cmp_count = 0;
  int n, t, ns, ss, sc, cc;
  always #25 clock_i = ~clock_i;
  adc_conversion_control DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(start_i),
    .converter_power_enable_i(pwr), .conversion_clock_divider_select_i(dv),
    .low_current_mode_select_i(lcm), .reference_source_select_i(rs),
    .temp_sensor_enable_i(temp_sensor_enable), .input_source_select_i(src),
    .external_channel_select_i(ch), .result_alignment_select_i(al),
    .interrupt_enable_i(ien), .irq_clear_i(clr), .pin_function_select_lo_i(lo),
    .pin_function_select_hi_i(hi), .core_result_i(core), .conversion_busy_flag_o(busy),
    .irq_flag_o(irq), .interrupt_o(intr), .result_high_reg_o(rh), .result_low_reg_o(rl),
    .core_power_o(c_pwr), .core_low_current_o(lc), .core_temp_sensor_on_o(ts),
    .core_sample_o(smp), .core_convert_o(cnv), .core_clock_tick_o(tick),
    .reference_route_o(er), .internal_route_o(ir), .analog_input_pin_o(ep),
    .pin_digital_disable_o(dis), .pin_pullup_disable_o(pu), .pin_direction_override_o(dr));
  adc_core_model core_model (.clock_i(clock_i), .power_i(c_pwr), .result_o(core));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // pulse start, then poll busy and count conversion clock ticks until it drops
  task automatic convert;
    @(posedge clock_i) start_i <= 1'b1;
    @(posedge clock_i) start_i <= 1'b0;
    @(posedge clock_i);
    #1 chk(busy, 1'b1);
    n = 0;
    t = 0;
    sc = 0;
    cc = 0;
    do
    begin
      @(posedge clock_i);
      #1 n += (tick === 1'b1);
      sc += (smp === 1'b1);
      cc += (cnv === 1'b1);
      t++;
    end
    while (busy === 1'b1 && t < 9000);
    if (t >= 9000)
    begin
      bad_count++;
      end_sim;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i) start_i <= 1'b1;
    @(posedge clock_i) start_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 chk({rh, rl, irq, busy}, 18'h00000);
    $display("reset and unpowered start test done");
    @(posedge clock_i) pwr <= 1'b1;
    repeat (10) @(posedge clock_i);
    foreach (rows[i])
    begin
      r = rows[i];
      @(posedge clock_i) src <= r.src;
      rs <= r.rs;
      dv <= r.dv;
      ch <= r.ch;
      al <= r.al;
      ien <= r.al;
      lcm <= (r.dv == 3'h7);
      temp_sensor_enable <= (r.rs == 2'h2 || r.src == 3'h2);
      lo <= (r.src inside {3'h0, 3'h6}) ? 16'h8001 : 16'h0000;
      hi <= (r.src inside {3'h0, 3'h6}) ? 16'h0008 : 16'h0000;
      repeat (2) @(posedge clock_i);
      convert();
      ss = (r.src == 3'h2) ? 46 : 4;
      ns = ss + 12;
      chk(n, ns);
      chk(sc, (ss << r.dv) + 1);
      chk(cc, 12 << r.dv);
      chk(t >= (ns << r.dv) && t <= (ns << r.dv) + 3, 1'b1);
      chk({busy, irq}, 2'b01);
      chk({rh, rl}, {r.eh, r.el});
      chk({ir, er}, {r.ir, r.er});
      chk(ep, r.ep);
      chk({dis, pu, dr}, {3{lo | hi}});
      chk({lc, ts}, {r.dv == 3'h7, r.rs == 2'h2 || r.src == 3'h2});
      @(posedge clock_i) clr <= 1'b1;
      #1 chk({intr, tick}, {r.al, 1'b0});
      @(posedge clock_i) clr <= 1'b0;
      #1 chk(irq, 1'b0);
      $display("row %0d done", i);
    end
    @(posedge clock_i) start_i <= 1'b1;
    @(posedge clock_i) start_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    pwr <= 1'b0;
    #1 chk(busy, 1'b1);
    repeat (2) @(posedge clock_i);
    #1 chk({busy, irq}, 2'b00);
    $display("abort test done");
    end_sim;
  end
endmodule
